/* File: design/hcos_oc_timer.sv */
// Over-current persistence timer counting in 2 ms steps.
// Assumes oc_active is already synchronised to aclk.
`timescale 1ns/1ps
`include "hcos_params.svh"
module hcos_oc_timer #(
  parameter int STEP_CYC = `HCOS_OC_STEP_CYC
) (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Condition and delay.
  input  wire logic       oc_active,
  input  wire logic [7:0] delay,
  // Result.
  output logic            oc_report
);
  localparam int PW = $clog2(STEP_CYC + 1);

  logic [PW-1:0] pre_reg, pre_next;
  logic [7:0]    cnt_reg, cnt_next;
  logic          rep_reg, rep_next;

  // Count whole steps while the condition holds.
  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    rep_next = rep_reg;
    if (!oc_active) begin
      pre_next = '0;
      cnt_next = 8'h00;
      rep_next = 1'b0;
    end else if (cnt_reg >= delay) begin
      rep_next = 1'b1;
    end else if (pre_reg == PW'(STEP_CYC - 1)) begin
      pre_next = '0;
      cnt_next = cnt_reg + 8'h01;
    end else begin
      pre_next = pre_reg + PW'(1);
    end
  end

  // State registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
      cnt_reg <= 8'h00;
      rep_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      rep_reg <= rep_next;
    end
  end

  assign oc_report = rep_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_OC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    !oc_active |=> !oc_report) else $error("report outlived condition");
  AST_OC_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(oc_report) |-> $past(cnt_reg) >= $past(delay) && $past(oc_active))
    else $error("report before delay expired");
  COV_OC: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(oc_report));
endmodule

/* File: design/hcos_params.svh */
// Constants for the hub configuration and power-mode block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef HCOS_PARAMS_SVH
`define HCOS_PARAMS_SVH

// Register byte offsets.
`define HCOS_A_VID    8'h00
`define HCOS_A_PID    8'h04
`define HCOS_A_DID    8'h08
`define HCOS_A_CFG    8'h0c
`define HCOS_A_NREM   8'h10
`define HCOS_A_DSELF  8'h14
`define HCOS_A_DBUS   8'h18
`define HCOS_A_OCD    8'h1c
`define HCOS_A_CTRL   8'h20
`define HCOS_A_STAT   8'h24

// Option bit positions in the CFG register.
`define HCOS_B_SELF   0
`define HCOS_B_HSD    1
`define HCOS_B_EOP    2
`define HCOS_B_GANG   3
`define HCOS_B_CMPD   4
`define HCOS_B_DYN    5

// Reset and default values.
`define HCOS_RST_CFG  6'h00
`define HCOS_DEF_DID  16'h0000
`define HCOS_RST_OCD  8'h00

// AXI responses.
`define HCOS_OKAY     2'h0
`define HCOS_SLVERR   2'h2

// Timing.
`define HCOS_CLK_NS       10
`define HCOS_OC_STEP_NS   2000000
`define HCOS_OC_STEP_CYC  (`HCOS_OC_STEP_NS / `HCOS_CLK_NS)
`define HCOS_DETACH_NS    20000
`define HCOS_DETACH_CYC   (`HCOS_DETACH_NS / `HCOS_CLK_NS)
`define HCOS_SAMPLE_CYC   12'h002

// Translator resources.
`define HCOS_TT_PER_PORT  4'h1
`define HCOS_TT_NP_BUFS   4'h4

`endif

/* File: design/hcos_pkg.sv */
// Types shared by the hub configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package hcos_pkg;

  // Main sequencer states.
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_LOAD   = 2'b01,
    ST_RUN    = 2'b10,
    ST_DROP   = 2'b11
  } hcos_state_e;

  // Configuration source.
  typedef enum logic [1:0] {
    SRC_DEF = 2'b00,
    SRC_SMB = 2'b01,
    SRC_EEP = 2'b10
  } hcos_src_e;

endpackage

/* File: design/hcos_top.sv */
// Hub configuration loader and power-mode controller.
// Assumes an AXI4-Lite master on aclk and asynchronous board pins.
`timescale 1ns/1ps
`include "hcos_params.svh"
module hcos_top #(
  parameter logic [15:0] DEF_VID  = 16'h1234, // Arbitrary value.
  parameter logic [15:0] DEF_PID  = 16'h5678, // Arbitrary value.
  parameter logic [15:0] DEF_REL  = `HCOS_DEF_DID,
  parameter int          OC_STEP  = `HCOS_OC_STEP_CYC
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Board pins.
  input  wire logic        config_source_select_hi,
  input  wire logic        config_source_select_lo,
  input  wire logic        local_power_detect,
  input  wire logic [1:0]  fixed_port_straps,
  input  wire logic        over_current,
  // Link state from the hub core.
  input  wire logic        link_full_speed,
  // Configuration results.
  output logic [15:0]      vendor_identifier,
  output logic [15:0]      product_identifier,
  output logic [15:0]      release_number,
  output logic             self_powered,
  output logic             hs_enable,
  output logic             eop_at_eof1_en,
  output logic             current_sense_ganged,
  output logic             compound_device,
  output logic [1:0]       fixed_ports,
  output logic [1:0]       port_enable,
  output logic [1:0]       port_power,
  output logic             upstream_connect,
  output logic             over_current_report,
  output logic             config_loaded
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merge written bytes into a register image.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Force disabled ports to run downward from port 2 (bit 1).
  function automatic logic [1:0] dis_order(input logic [1:0] d);
    return {d[1] | d[0], d[0]};
  endfunction

  // Mapped register test.
  function automatic logic mapped(input logic [7:0] a);
    return {a[7:2], 2'b00} <= `HCOS_A_STAT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: sel hi, sel lo, power, straps, over-current.

  logic [5:0] sync_a_reg, sync_b_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_reg <= 6'h00;
      sync_b_reg <= 6'h00;
    end else begin
      sync_a_reg <= {config_source_select_hi, config_source_select_lo,
                     local_power_detect, fixed_port_straps, over_current};
      sync_b_reg <= sync_a_reg;
    end
  end

  logic       lp_s;
  logic [1:0] straps_s;
  assign lp_s     = sync_b_reg[3];
  assign straps_s = sync_b_reg[2:1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic        aw_rdy_reg, aw_rdy_next, bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic        ar_rdy_reg, ar_rdy_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next, rd_word;
  logic        wr_fire, rd_fire;
  logic [7:0]  wa;

  hcos_pkg::hcos_state_e st_reg, st_next;
  hcos_pkg::hcos_src_e   src_reg, src_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [15:0] vid_reg, vid_next, pid_reg, pid_next, did_reg, did_next;
  logic [5:0]  cfg_reg, cfg_next;
  logic [1:0]  nrem_reg, nrem_next, dself_reg, dself_next;
  logic [1:0]  dbus_reg, dbus_next;
  logic [7:0]  ocd_reg, ocd_next;
  logic        sp_reg, sp_next, lp_reg, lp_next;
  logic        oc_rep;

  assign wr_fire = aw_rdy_reg & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire = ar_rdy_reg & s_axi_arvalid;
  assign wa      = {s_axi_awaddr[7:2], 2'b00};

  // Read data mux.
  always_comb begin
    logic [7:0] ra;
    ra = {s_axi_araddr[7:2], 2'b00};
    rd_word = 32'h0000_0000;
    if (ra == `HCOS_A_VID) rd_word[15:0] = vid_reg;
    else if (ra == `HCOS_A_PID) rd_word[15:0] = pid_reg;
    else if (ra == `HCOS_A_DID) rd_word[15:0] = did_reg;
    else if (ra == `HCOS_A_CFG) rd_word[5:0] = cfg_reg;
    else if (ra == `HCOS_A_NREM) rd_word[1:0] = nrem_reg;
    else if (ra == `HCOS_A_DSELF) rd_word[1:0] = dself_reg;
    else if (ra == `HCOS_A_DBUS) rd_word[1:0] = dbus_reg;
    else if (ra == `HCOS_A_OCD) rd_word[7:0] = ocd_reg;
    else if (ra == `HCOS_A_STAT) begin
      rd_word[15:0] = {`HCOS_TT_PER_PORT, `HCOS_TT_NP_BUFS, 1'b0,
                       lp_s, oc_rep, upstream_connect, sp_reg,
                       config_loaded, src_reg};
    end
  end

  // Handshake and response next values.
  always_comb begin
    aw_rdy_next = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_reg & ~bvalid_reg;
    bvalid_next = wr_fire | (bvalid_reg & ~s_axi_bready);
    bresp_next  = bresp_reg;
    if (wr_fire) bresp_next = mapped(wa) ? `HCOS_OKAY : `HCOS_SLVERR;
    ar_rdy_next = s_axi_arvalid & ~ar_rdy_reg & ~rvalid_reg;
    rvalid_next = rd_fire | (rvalid_reg & ~s_axi_rready);
    rdata_next  = rd_fire ? rd_word : rdata_reg;
    rresp_next  = rresp_reg;
    if (rd_fire) rresp_next = mapped(s_axi_araddr) ? `HCOS_OKAY : `HCOS_SLVERR;
  end

  // Bus registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `HCOS_OKAY;
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `HCOS_OKAY;
    end else begin
      aw_rdy_reg <= aw_rdy_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      ar_rdy_reg <= ar_rdy_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_awready = aw_rdy_reg;
  assign s_axi_wready  = aw_rdy_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ar_rdy_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection, loading and dynamic power sequencing.

  always_comb begin
    logic [31:0] m;
    m = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
    st_next = st_reg;
    src_next = src_reg;
    cnt_next = cnt_reg;
    vid_next = vid_reg;
    pid_next = pid_reg;
    did_next = did_reg;
    cfg_next = cfg_reg;
    nrem_next = nrem_reg;
    dself_next = dself_reg;
    dbus_next = dbus_reg;
    ocd_next = ocd_reg;
    sp_next = sp_reg;
    lp_next = lp_reg;
    case (st_reg)
      hcos_pkg::ST_SAMPLE: begin
        if (cnt_reg == `HCOS_SAMPLE_CYC) begin
          case (sync_b_reg[5:4])
            2'b00: src_next = hcos_pkg::SRC_DEF;
            2'b01: src_next = hcos_pkg::SRC_SMB;
            default: src_next = hcos_pkg::SRC_EEP;
          endcase
          st_next = hcos_pkg::ST_LOAD;
          cnt_next = 12'h000;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      hcos_pkg::ST_LOAD: begin
        if (src_reg == hcos_pkg::SRC_DEF) begin
          vid_next = DEF_VID;
          pid_next = DEF_PID;
          did_next = DEF_REL;
          cfg_next = `HCOS_RST_CFG;
          cfg_next[`HCOS_B_SELF] = lp_s;
          cfg_next[`HCOS_B_GANG] = lp_s;
          cfg_next[`HCOS_B_CMPD] = |straps_s;
          nrem_next = straps_s;
          sp_next = lp_s;
          lp_next = lp_s;
          st_next = hcos_pkg::ST_RUN;
        end else if (wr_fire) begin
          if (wa == `HCOS_A_VID) vid_next = 16'(merge({16'h0, vid_reg},
            s_axi_wdata, s_axi_wstrb));
          else if (wa == `HCOS_A_PID) pid_next = 16'(merge({16'h0, pid_reg},
            s_axi_wdata, s_axi_wstrb));
          else if (wa == `HCOS_A_DID) did_next = 16'(merge({16'h0, did_reg},
            s_axi_wdata, s_axi_wstrb));
          else if (wa == `HCOS_A_CFG && s_axi_wstrb[0]) cfg_next = m[5:0];
          else if (wa == `HCOS_A_NREM && s_axi_wstrb[0]) nrem_next = m[1:0];
          else if (wa == `HCOS_A_DSELF && s_axi_wstrb[0]) dself_next = m[1:0];
          else if (wa == `HCOS_A_DBUS && s_axi_wstrb[0]) dbus_next = m[1:0];
          else if (wa == `HCOS_A_OCD && s_axi_wstrb[0]) ocd_next = m[7:0];
          else if (wa == `HCOS_A_CTRL && s_axi_wstrb[0] && m[0]) begin
            st_next = hcos_pkg::ST_RUN;
            sp_next = cfg_reg[`HCOS_B_DYN] ? lp_s : cfg_reg[`HCOS_B_SELF];
            lp_next = lp_s;
          end
        end
      end
      hcos_pkg::ST_RUN: begin
        if (cfg_reg[`HCOS_B_DYN] && lp_s != lp_reg) begin
          st_next = hcos_pkg::ST_DROP;
          cnt_next = 12'h000;
        end
      end
      default: begin
        if (cnt_reg == 12'(`HCOS_DETACH_CYC - 1)) begin
          st_next = hcos_pkg::ST_RUN;
          sp_next = lp_s;
          lp_next = lp_s;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
    endcase
  end

  // Sequencer and configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= hcos_pkg::ST_SAMPLE;
      src_reg <= hcos_pkg::SRC_DEF;
      cnt_reg <= 12'h000;
      vid_reg <= DEF_VID;
      pid_reg <= DEF_PID;
      did_reg <= DEF_REL;
      cfg_reg <= `HCOS_RST_CFG;
      nrem_reg <= 2'h0;
      dself_reg <= 2'h0;
      dbus_reg <= 2'h0;
      ocd_reg <= `HCOS_RST_OCD;
      sp_reg <= 1'b0;
      lp_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      src_reg <= src_next;
      cnt_reg <= cnt_next;
      vid_reg <= vid_next;
      pid_reg <= pid_next;
      did_reg <= did_next;
      cfg_reg <= cfg_next;
      nrem_reg <= nrem_next;
      dself_reg <= dself_next;
      dbus_reg <= dbus_next;
      ocd_reg <= ocd_next;
      sp_reg <= sp_next;
      lp_reg <= lp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs derived from the next configuration.

  logic [12:0] out_reg, out_next;
  logic        run_n;
  logic [1:0]  dis_n;
  always_comb begin
    run_n = st_next == hcos_pkg::ST_RUN;
    dis_n = sp_next ? dis_order(dself_next)
                    : dis_order(dbus_next);
    out_next = {run_n, // upstream attach
      ~dis_n & {2{run_n}}, // port power
      ~dis_n & {2{run_n}}, // port enable
      nrem_next,
      cfg_next[`HCOS_B_CMPD],
      cfg_next[`HCOS_B_GANG],
      cfg_next[`HCOS_B_EOP] & link_full_speed,
      ~cfg_next[`HCOS_B_HSD],
      sp_next,
      st_next != hcos_pkg::ST_SAMPLE && st_next != hcos_pkg::ST_LOAD};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) out_reg <= 13'h0000;
    else out_reg <= out_next;
  end

  assign {upstream_connect, port_power, port_enable, fixed_ports,
          compound_device, current_sense_ganged, eop_at_eof1_en,
          hs_enable, self_powered, config_loaded} = out_reg;
  assign vendor_identifier  = vid_reg;
  assign product_identifier = pid_reg;
  assign release_number     = did_reg;
  assign over_current_report = oc_rep;

  // Over-current persistence.
  hcos_oc_timer #(.STEP_CYC(OC_STEP)) u_oc (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .oc_active (sync_b_reg[0] & config_loaded),
    .delay     (ocd_reg),
    .oc_report (oc_rep)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic def_ld;
  assign def_ld = config_loaded && src_reg == hcos_pkg::SRC_DEF;

  AST_NO_EARLY_ATTACH: assert property (
    upstream_connect |-> config_loaded) else $error("attached early");
  AST_CFG_STABLE: assert property (
    config_loaded && $past(config_loaded) |-> $stable(vid_reg) &&
    $stable(cfg_reg) && $stable(ocd_reg)) else $error("config moved");
  AST_DEF_VID: assert property (
    def_ld |-> vendor_identifier == DEF_VID) else $error("bad default id");
  AST_DEF_GANG: assert property (
    def_ld |-> current_sense_ganged == self_powered) else $error("gang");
  AST_DEF_CMPD: assert property (
    def_ld |-> compound_device == |fixed_ports) else $error("compound");
  AST_SELF_DIS: assert property (
    self_powered && |dself_reg |-> !port_enable[1] && !port_power[1])
    else $error("self disabled port live");
  AST_BUS_DIS: assert property (
    !self_powered && |dbus_reg |-> !port_enable[1] &&
    (!dbus_reg[0] || port_enable == 2'b00))
    else $error("bus disabled port live");
  AST_DYN_DROP: assert property (
    st_reg == hcos_pkg::ST_RUN && cfg_reg[`HCOS_B_DYN] && lp_s != lp_reg
    |=> (!upstream_connect && port_power == 2'b00) [*8])
    else $error("no drop on power change");
  AST_DYN_SELF: assert property (
    upstream_connect && cfg_reg[`HCOS_B_DYN] |-> self_powered == lp_reg)
    else $error("dynamic mode wrong");
  AST_HS_OFF: assert property (
    config_loaded && cfg_reg[`HCOS_B_HSD] |-> !hs_enable)
    else $error("high speed offered");

  COV_DEF_ATTACH: cover property ($rose(upstream_connect) && def_ld);
  COV_DYN_SWITCH: cover property (st_reg == hcos_pkg::ST_DROP ##1
    st_reg == hcos_pkg::ST_RUN);
  COV_LOADED_BUS: cover property ($rose(config_loaded) &&
    src_reg != hcos_pkg::SRC_DEF);
endmodule

/* File: tb/hcos_cfg_source.sv */
// Configuration source model: an AXI4-Lite master that loads the hub.
// Assumes the bench starts each call just after a rising edge of aclk.
`timescale 1ns/1ps
`include "hcos_params.svh"
module hcos_cfg_source (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels.
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // One write; each channel is held until its own ready.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One read; rready stays up until rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Full load; a compound hub always gets fixed ports marked.
  task automatic load(input logic [5:0] cfg, input logic [1:0] nrem,
                      input logic [1:0] ds, input logic [1:0] db,
                      input logic [7:0] ocd);
    logic [1:0] r;
    logic [1:0] nr;
    nr = (cfg[4] && nrem == 2'b00) ? 2'b11 : nrem;
    wr(`HCOS_A_VID, 32'h2468, r);
    wr(`HCOS_A_PID, 32'h1357, r);
    wr(`HCOS_A_DID, 32'h0102, r);
    wr(`HCOS_A_CFG, {26'h0, cfg}, r);
    wr(`HCOS_A_NREM, {30'h0, nr}, r);
    wr(`HCOS_A_DSELF, {30'h0, ds}, r);
    wr(`HCOS_A_DBUS, {30'h0, db}, r);
    wr(`HCOS_A_OCD, {24'h0, ocd}, r);
    wr(`HCOS_A_CTRL, 32'h1, r);
  endtask
endmodule

/* File: tb/hub_config_option_select_test.sv */
// Self-checking bench for the hub configuration block.
// Assumes the design files and the configuration source model.
`timescale 1ns/1ps
`include "hcos_params.svh"
module hub_config_option_select_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, fixed_port_straps, fixed_ports;
  logic [1:0]  port_enable, port_power;
  logic        config_source_select_hi, config_source_select_lo;
  logic        local_power_detect, over_current, link_full_speed;
  logic [15:0] vendor_identifier, product_identifier, release_number;
  logic        self_powered, hs_enable, eop_at_eof1_en, compound_device;
  logic        current_sense_ganged, upstream_connect;
  logic        over_current_report, config_loaded;
  int          mismatches = 0;
  int          samples_checked = 0;
  hcos_top #(.OC_STEP(10)) u_hcos_top (.*);
  hcos_cfg_source u_hcos_cfg_source (.*);
  // Clock at 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Compare one result and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run.
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset for 12 cycles with the source pins and power pin held.
  task automatic rst(input logic [1:0] sel, input logic lp);
    aresetn <= 1'b0;
    {config_source_select_hi, config_source_select_lo} <= sel;
    local_power_detect <= lp;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Watchdog.
  initial begin
    repeat (10000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
  // Test sequence.
  initial begin
    {aresetn, over_current, link_full_speed} = 3'b000;
    fixed_port_straps = 2'b10;
    rst(2'b00, 1'b1);
    repeat (10) @(posedge aclk);
    chk(32'(vendor_identifier), 32'h1234);
    chk(32'(product_identifier), 32'h5678);
    chk(32'(release_number), 32'h0);
    chk(32'(self_powered), 32'h1);
    chk(32'(current_sense_ganged), 32'h1);
    chk(32'(fixed_ports), 32'h2);
    chk(32'(compound_device), 32'h1);
    chk(32'(upstream_connect), 32'h1);
    chk(32'(hs_enable), 32'h1);
    $display("test defaults done");
    rst(2'b10, 1'b1);
    repeat (8) @(posedge aclk);
    chk(32'({config_loaded, upstream_connect}), 32'h0);
    u_hcos_cfg_source.load(6'h07, 2'b00, 2'b01, 2'b00, 8'h02);
    @(posedge aclk);
    chk(32'(vendor_identifier), 32'h2468);
    chk(32'(product_identifier), 32'h1357);
    chk(32'(release_number), 32'h0102);
    chk(32'(self_powered), 32'h1);
    chk(32'(hs_enable), 32'h0);
    chk(32'(port_enable), 32'h0);
    u_hcos_cfg_source.wr(`HCOS_A_VID, 32'hffff, r);
    chk(32'(vendor_identifier), 32'h2468);
    chk(32'(r), 32'h0);
    link_full_speed <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(eop_at_eof1_en), 32'h1);
    link_full_speed <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(eop_at_eof1_en), 32'h0);
    u_hcos_cfg_source.rd(`HCOS_A_STAT, d, r);
    chk(32'(d[15:8]), 32'h14);
    chk(32'(d[1:0]), 32'h2);
    u_hcos_cfg_source.rd(8'h28, d, r);
    chk({d[29:0], r}, 32'h2);
    u_hcos_cfg_source.wr(8'h28, 32'h0, r);
    chk(32'(r), 32'h2);
    $display("test loaded source done");
    // Broken over-current must restart the count.
    over_current <= 1'b1;
    repeat (15) @(posedge aclk);
    over_current <= 1'b0;
    repeat (3) @(posedge aclk);
    over_current <= 1'b1;
    repeat (15) @(posedge aclk);
    chk(32'(over_current_report), 32'h0);
    repeat (20) @(posedge aclk);
    chk(32'(over_current_report), 32'h1);
    over_current <= 1'b0;
    $display("test over-current done");
    rst(2'b01, 1'b1);
    repeat (6) @(posedge aclk);
    u_hcos_cfg_source.load(6'h30, 2'b00, 2'b00, 2'b10, 8'h00);
    @(posedge aclk);
    chk(32'({compound_device, fixed_ports}), 32'h7);
    chk(32'({self_powered, port_enable}), 32'h7);
    local_power_detect <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'({upstream_connect, port_power}), 32'h0);
    repeat (2010) @(posedge aclk);
    chk(32'({self_powered, upstream_connect}), 32'h1);
    chk(32'(port_enable), 32'h1);
    $display("test dynamic power done");
    stop_test();
  end
endmodule
